// *** ssp_peer.sv ***
// Behavioural far-side party of the four-wire link
`timescale 1ns/1ps
module ssp_peer (
    input  wire logic i_sck,       // Resolved shift clock wire
    input  wire logic i_sdo,       // Data from the port
    output logic      o_sck,       // Clock we drive as link master
    output logic      o_ss_n,      // Select, active low
    output logic      o_sdi,       // Data to the port
    output logic [15:0] o_rx       // Word taken from the port
);
    logic [15:0] tx_reg;
    initial begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
        tx_reg = 16'h0000;
        o_rx = 16'h0000;
    end
    assign o_sdi = tx_reg[15];
    // Sample on rising, present next bit on falling; fill with inverted bits
    always @(posedge i_sck) o_rx <= {o_rx[14:0], i_sdo};
    always @(negedge i_sck) tx_reg <= {tx_reg[14:0], ~tx_reg[15]};
    task automatic load(input logic [15:0] w);
        tx_reg = w;
    endtask
    // Clock runs only inside the frame, off the system clock phase
    task automatic frame();
        #7;
        o_ss_n = 1'b0;
        #160;
        repeat (16) begin
            o_sck = 1'b1;
            #80;
            o_sck = 1'b0;
            #80;
        end
        #160;
        o_ss_n = 1'b1;
    endtask
endmodule // ssp_peer

// *** ssp_pkg.sv ***
// Shared constants for the serial port: register map, field positions, sizes
package ssp_pkg;

    localparam int WORD_W = 16;
    localparam int CNT_W  = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IRQ_W  = 3;
    localparam int DIV_W  = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_BUF   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CFG   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ISTS  = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_IMASK = 8'h10;

    // Status and control register fields
    localparam int STAT_EN   = 15;
    localparam int STAT_SIDL = 13;
    localparam int STAT_ROV  = 6;
    localparam int STAT_TBF  = 1;
    localparam int STAT_RBF  = 0;

    // Configuration register fields
    localparam int CFG_MASTER = 0;

    // Interrupt status and mask fields
    localparam int IRQ_RX  = 0;
    localparam int IRQ_TX  = 1;
    localparam int IRQ_OVF = 2;

    // Clock rate and link timing
    localparam int CLK_HZ        = 50_000_000;
    localparam int SCK_HALF_NS   = 80;
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;

    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
    localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
    localparam logic [DIV_W-1:0] DIV_ONE  = 8'h01;

endpackage : ssp_pkg

// *** ssp_sync.sv ***
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module ssp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,    // System clock
    input  wire logic         i_rst_n,  // Synchronised reset, active low
    input  wire logic [W-1:0] i_async,  // Asynchronous inputs
    output logic      [W-1:0] o_sync    // Synchronised outputs
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } ssp_sync_s;

    ssp_sync_s s_reg;
    ssp_sync_s s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.stage1 = i_async;
        s_next.stage2 = s_reg.stage1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_sync = s_reg.stage2;

endmodule // ssp_sync

// *** ssp_top.sv ***
// Serial port with 16-bit shift register, APB register access and interrupt
//
// Operation
// RULE1: Data moves through a 16-bit shift register with separate holding buffers toward software.
// RULE2: The link has serial in, serial out, shift clock and an active-low select.
// RULE3: As master the port drives the shift clock, as slave it takes the clock from outside.
// RULE4: Writing the buffer location loads the transmit buffer and sets tx_buffer_full.
// RULE5: Moving the transmit word into the shift register clears tx_buffer_full.
// RULE6: A word that completes while the receive buffer is unread is dropped and sets rx_overflow.
`timescale 1ns/1ps
module ssp_top
    import ssp_pkg::*;
#(
    parameter logic [ssp_pkg::DIV_W-1:0] DIV_HALF = ssp_pkg::DIV_W'(ssp_pkg::SCK_HALF_CYC)
) (
    input  wire logic                        I_CLK,        // System clock, 50 MHz
    input  wire logic                        I_ARST_N,     // Asynchronous reset, active low
    input  wire logic                        I_PSEL,       // APB select
    input  wire logic                        I_PENABLE,    // APB enable
    input  wire logic                        I_PWRITE,     // APB direction
    input  wire logic [ssp_pkg::ADDR_W-1:0]  I_PADDR,      // APB byte address
    input  wire logic [ssp_pkg::DATA_W-1:0]  I_PWDATA,     // APB write data
    output logic      [ssp_pkg::DATA_W-1:0]  O_PRDATA,     // APB read data
    output logic                             O_PREADY,     // APB ready
    output logic                             O_PSLVERR,    // APB error, unmapped address
    input  wire logic                        I_IDLE,       // Device idle mode request
    input  wire logic                        I_SDI,        // Serial data in pin
    output logic                             O_SDO,        // Serial data out pin
    output logic                             O_SDO_OE_N,   // Data out enable, low drives
    input  wire logic                        I_SCK,        // Shift clock pin, input side
    output logic                             O_SCK,        // Shift clock pin, output side
    output logic                             O_SCK_OE_N,   // Shift clock enable, low drives
    input  wire logic                        I_SS_N,       // Select pin, active low
    output logic                             O_IRQ         // Interrupt, active high level
);

    typedef struct packed {
        logic              en;
        logic              sidl;
        logic              master;
        logic [WORD_W-1:0] txb;
        logic [WORD_W-1:0] rxb;
        logic [WORD_W-1:0] sr;
        logic              tbf;
        logic              rbf;
        logic              rov;
        logic [IRQ_W-1:0]  ists;
        logic [IRQ_W-1:0]  imask;
        logic              irq;
        logic              busy;
        logic [CNT_W-1:0]  cnt;
        logic [DIV_W-1:0]  div;
        logic              sck_out;
        logic              sck_prev;
        logic              sdo;
        logic              sdo_oe_n;
        logic              sck_oe_n;
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } ssp_state_s;

    // Pin enables reset high so nothing is driven until the port is enabled
    localparam ssp_state_s RST_STATE = '{sdo_oe_n: 1'b1, sck_oe_n: 1'b1, default: '0};

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisation

    logic [1:0] rst_sync_reg;
    logic       rst_n;
    logic [2:0] pins_sync;
    logic       sck_in;
    logic       sdi_in;
    logic       ss_n_in;

    // Reset asserts at once and releases two edges after the pin
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // Link pins cross into the clock domain before any logic reads them
    ssp_sync #(
        .W (3)
    ) u_pin_sync (
        .i_clk   (I_CLK),
        .i_rst_n (rst_n),
        .i_async ({I_SCK, I_SDI, I_SS_N}),
        .o_sync  (pins_sync)
    );

    assign sck_in  = pins_sync[2];
    assign sdi_in  = pins_sync[1];
    assign ss_n_in = pins_sync[0];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    ssp_state_s s_reg;
    ssp_state_s s_next;

    always_comb begin
        logic              acc;
        logic              done_xfer;
        logic              hit;
        logic              run;
        logic              tick;
        logic              rise;
        logic              fall;
        logic              word_done;
        logic [WORD_W-1:0] word;
        logic [DATA_W-1:0] rdata;

        s_next    = s_reg;
        word_done = 1'b0;
        word      = '0;
        rdata     = '0;
        hit       = 1'b1;
        tick      = 1'b0;
        acc       = 1'b0;
        done_xfer = 1'b0;
        run       = 1'b0;
        rise      = 1'b0;
        fall      = 1'b0;

        // APB: one wait cycle, effects at the edge that samples ready
        acc       = I_PSEL && I_PENABLE && !s_reg.pready;
        done_xfer = I_PSEL && I_PENABLE && s_reg.pready;

        if (I_PADDR == ADDR_BUF) begin
            rdata[WORD_W-1:0] = s_reg.rxb;
        end else if (I_PADDR == ADDR_STAT) begin
            rdata[STAT_EN]   = s_reg.en;
            rdata[STAT_SIDL] = s_reg.sidl;
            rdata[STAT_ROV]  = s_reg.rov;
            rdata[STAT_TBF]  = s_reg.tbf;
            rdata[STAT_RBF]  = s_reg.rbf;
        end else if (I_PADDR == ADDR_CFG) begin
            rdata[CFG_MASTER] = s_reg.master;
        end else if (I_PADDR == ADDR_ISTS) begin
            rdata[IRQ_W-1:0] = s_reg.ists;
        end else if (I_PADDR == ADDR_IMASK) begin
            rdata[IRQ_W-1:0] = s_reg.imask;
        end else begin
            hit = 1'b0;
        end

        s_next.pready  = acc;
        s_next.pslverr = acc && !hit;
        s_next.prdata  = (acc && hit && !I_PWRITE) ? rdata : '0;

        // Software clears and control writes come first so hardware sets win
        if (done_xfer && hit) begin
            if (!I_PWRITE) begin
                if (I_PADDR == ADDR_BUF) begin
                    s_next.rbf = 1'b0;
                end
            end else if (I_PADDR == ADDR_STAT) begin
                s_next.en   = I_PWDATA[STAT_EN];
                s_next.sidl = I_PWDATA[STAT_SIDL];
                if (I_PWDATA[STAT_ROV]) begin
                    s_next.rov = 1'b0;
                end
            end else if (I_PADDR == ADDR_CFG) begin
                s_next.master = I_PWDATA[CFG_MASTER];
            end else if (I_PADDR == ADDR_ISTS) begin
                s_next.ists = s_reg.ists & ~I_PWDATA[IRQ_W-1:0];
            end else if (I_PADDR == ADDR_IMASK) begin
                s_next.imask = I_PWDATA[IRQ_W-1:0];
            end
        end

        // Shift engine
        run             = s_reg.en && !(s_reg.sidl && I_IDLE);
        rise            = sck_in && !s_reg.sck_prev;
        fall            = !sck_in && s_reg.sck_prev;
        s_next.sck_prev = sck_in;

        // Divider gives one tick per half period of the shift clock
        if (s_reg.div >= DIV_HALF - DIV_ONE) begin
            s_next.div = '0;
            tick       = 1'b1;
        end else begin
            s_next.div = s_reg.div + DIV_ONE;
        end

        if (!run) begin
            s_next.busy    = 1'b0;
            s_next.cnt     = '0;
            s_next.sck_out = 1'b0;
            s_next.div     = '0;
        end else if (s_reg.master) begin
            // Master: clock and data paced by the divider tick
            if (!s_reg.busy) begin
                s_next.div = '0;
                if (s_reg.tbf) begin
                    s_next.sr   = s_reg.txb;                            // RULE5
                    s_next.sdo  = s_reg.txb[WORD_W-1];
                    s_next.tbf  = 1'b0;                                 // RULE5
                    s_next.busy = 1'b1;
                    s_next.cnt  = '0;
                    s_next.ists[IRQ_TX] = 1'b1;
                end
            end else if (tick) begin
                if (!s_reg.sck_out) begin
                    s_next.sck_out = 1'b1;                              // RULE3
                    s_next.sr      = {s_reg.sr[WORD_W-2:0], sdi_in};    // RULE1
                    s_next.cnt     = s_reg.cnt + CNT_ONE;
                end else begin
                    s_next.sck_out = 1'b0;                              // RULE3
                    s_next.sdo     = s_reg.sr[WORD_W-1];
                    if (s_reg.cnt == CNT_FULL) begin
                        s_next.busy = 1'b0;
                        s_next.cnt  = '0;
                        word_done   = 1'b1;
                        word        = s_reg.sr;
                    end
                end
            end
        end else begin
            // Slave: edges found on the synchronised pin clock
            s_next.sck_out = 1'b0;
            s_next.busy    = 1'b0;
            if (ss_n_in) begin
                s_next.cnt = '0;                                        // RULE2
            end else if (rise) begin
                s_next.sr  = {s_reg.sr[WORD_W-2:0], sdi_in};            // RULE1
                s_next.cnt = s_reg.cnt + CNT_ONE;
                if (s_reg.cnt == CNT_LAST) begin
                    s_next.cnt = '0;
                    word_done  = 1'b1;
                    word       = {s_reg.sr[WORD_W-2:0], sdi_in};
                end
            end else if (fall) begin
                s_next.sdo = s_reg.sr[WORD_W-1];
            end
            // A pending word is taken only on a word boundary
            if (s_reg.cnt == '0 && !rise && s_reg.tbf) begin
                s_next.sr   = s_reg.txb;                                // RULE5
                s_next.sdo  = s_reg.txb[WORD_W-1];
                s_next.tbf  = 1'b0;                                     // RULE5
                s_next.ists[IRQ_TX] = 1'b1;
            end
        end

        // Completed word goes to the receive buffer unless it is still unread
        if (word_done) begin
            if (s_next.rbf) begin
                s_next.rov           = 1'b1;                            // RULE6
                s_next.ists[IRQ_OVF] = 1'b1;
            end else begin
                s_next.rxb          = word;                             // RULE1
                s_next.rbf          = 1'b1;
                s_next.ists[IRQ_RX] = 1'b1;
            end
        end

        // Buffer write last: a fresh word stays pending after a same-cycle load
        if (done_xfer && hit && I_PWRITE && I_PADDR == ADDR_BUF) begin
            s_next.txb = I_PWDATA[WORD_W-1:0];                          // RULE4
            s_next.tbf = 1'b1;                                          // RULE4
        end

        // A released clock pin drops its level at once; enables follow the next state
        s_next.sck_oe_n = !(s_next.en && s_next.master);                // RULE3
        if (s_next.sck_oe_n) begin
            s_next.sck_out = 1'b0;                                      // RULE3
        end
        s_next.sdo_oe_n = !(s_next.en && (s_next.master || !ss_n_in));  // RULE2
        s_next.irq      = |(s_next.ists & s_next.imask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Whole state in one register, reset by the internal copy
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign O_PRDATA   = s_reg.prdata;
    assign O_PREADY   = s_reg.pready;
    assign O_PSLVERR  = s_reg.pslverr;
    assign O_SDO      = s_reg.sdo;
    assign O_SDO_OE_N = s_reg.sdo_oe_n;
    assign O_SCK      = s_reg.sck_out;
    assign O_SCK_OE_N = s_reg.sck_oe_n;
    assign O_IRQ      = s_reg.irq;

endmodule // ssp_top

// *** ssp_top_monitor.sv ***
// Assertion checker on the serial port top-level ports
`timescale 1ns/1ps
module ssp_top_monitor
    import ssp_pkg::*;
#(
    parameter logic [ssp_pkg::DIV_W-1:0] DIV_HALF = 8'h04
) (
    input wire logic                       I_CLK,       // System clock
    input wire logic                       I_ARST_N,    // Reset pin, active low
    input wire logic                       I_PSEL,      // APB select
    input wire logic                       I_PENABLE,   // APB enable
    input wire logic                       I_PWRITE,    // APB direction
    input wire logic [ssp_pkg::ADDR_W-1:0] I_PADDR,     // APB address
    input wire logic [ssp_pkg::DATA_W-1:0] I_PWDATA,    // APB write data
    input wire logic [ssp_pkg::DATA_W-1:0] O_PRDATA,    // APB read data
    input wire logic                       O_PREADY,    // APB ready
    input wire logic                       O_PSLVERR,   // APB error
    input wire logic                       O_SDO,       // Serial data out
    input wire logic                       O_SCK,       // Driven shift clock
    input wire logic                       O_SCK_OE_N,  // Clock enable, low drives
    input wire logic                       O_SDO_OE_N,  // Data enable, low drives
    input wire logic                       O_IRQ        // Interrupt level
);
    logic [7:0] hi_cnt;
    logic       wr_done;
    // Counts sampled high cycles of the driven shift clock
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) hi_cnt <= 8'h00;
        else hi_cnt <= O_SCK ? hi_cnt + 8'h01 : 8'h00;
    end
    assign wr_done = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    AST_READY_PULSE: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held longer than one cycle");
    AST_READY_WAIT: assert property (I_PSEL && $rose(I_PENABLE) |=> O_PREADY)
        else $error("ready not after one wait state");
    AST_ERR_ZERO: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
        else $error("error response without ready or with data");
    AST_SCK_HALF: assert property ($fell(O_SCK) |-> hi_cnt == DIV_HALF)
        else $error("shift clock high phase has wrong length");
    AST_SCK_OWNER: assert property (O_SCK |-> !O_SCK_OE_N)
        else $error("shift clock toggles while not driven");
    AST_OE_PAIR: assert property (!O_SCK_OE_N |-> !O_SDO_OE_N)
        else $error("master drives clock but not data out");
    AST_SDO_HOLD: assert property (O_SCK && $past(O_SCK) |-> $stable(O_SDO))
        else $error("data out changed while clock high");
    AST_SLAVE_OE: assert property (wr_done && I_PADDR == ADDR_CFG && !I_PWDATA[0]
        |-> ##[1:3] O_SCK_OE_N)
        else $error("slave mode still drives shift clock");
    AST_IRQ_MASKED: assert property (wr_done && I_PADDR == ADDR_IMASK
        && I_PWDATA[2:0] == 3'h0 |-> ##2 !O_IRQ)
        else $error("interrupt high with all sources masked");
    COV_BUF_WRITE: cover property (wr_done && I_PADDR == ADDR_BUF);
    COV_SCK_FALL: cover property ($fell(O_SCK));
    COV_SLVERR: cover property (O_PSLVERR);
    COV_IRQ: cover property ($rose(O_IRQ));
endmodule // ssp_top_monitor

bind ssp_top ssp_top_monitor #(.DIV_HALF(DIV_HALF)) ssp_top_monitor_inst (
    .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_SDO(O_SDO), .O_SCK(O_SCK),
    .O_SCK_OE_N(O_SCK_OE_N), .O_SDO_OE_N(O_SDO_OE_N), .O_IRQ(O_IRQ));

// *** test_spi_serial_port.sv ***
// Self-checking bench for the serial port over APB and the link
`timescale 1ns/1ps
module test_spi_serial_port;
    import ssp_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, idle = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic prdy, perr, e, sdo, sdo_oe_n, sck, sck_oe_n, irq, p_sck, p_ss_n, p_sdi, sck_w, sdo_w;
    logic [15:0] p_rx;
    int err_count = 0, n_checks = 0;
    always #10 clk = ~clk;
    assign sck_w = sck_oe_n ? p_sck : sck;
    // Released data pin reads back inverted so a late enable shows up
    assign sdo_w = sdo_oe_n ? ~sdo : sdo;
    ssp_top #(.DIV_HALF(8'h04)) ssp_top_inst (.I_CLK(clk), .I_ARST_N(rst_n),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(prdy), .O_PSLVERR(perr),
        .I_IDLE(idle), .I_SDI(p_sdi), .O_SDO(sdo), .O_SDO_OE_N(sdo_oe_n),
        .I_SCK(sck_w), .O_SCK(sck), .O_SCK_OE_N(sck_oe_n), .I_SS_N(p_ss_n), .O_IRQ(irq));
    ssp_peer ssp_peer_inst (.i_sck(sck_w), .i_sdo(sdo_w), .o_sck(p_sck),
        .o_ss_n(p_ss_n), .o_sdi(p_sdi), .o_rx(p_rx));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
        n_checks++;
        if (s !== x) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (prdy !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        if (n == 16) chk(0, 1, "ready timeout");
        q = prdata;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
        apb(0, a, 0);
        chk(q, x, m);
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        q = 0;
        while (q[b] !== 1'b1 && n < 300) begin
            apb(0, ADDR_STAT, 0);
            n++;
        end
        chk(q[b], 1, "status bit wait");
    endtask
    task automatic irq_is(input logic x);
        repeat (2) @(posedge clk);
        chk(irq, x, "irq level");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 5; i++) rd(8'(i * 4), 0, "reset value");
        apb(0, 8'h14, 0);
        chk(e, 1, "unmapped error");
        chk(q, 0, "unmapped data");
        $display("test reset done");
        // Master: two words back to back, second dropped on overflow
        ssp_peer_inst.load(16'ha5c3);
        apb(1, ADDR_CFG, 32'h1);
        apb(1, ADDR_IMASK, 32'h7);
        apb(1, ADDR_STAT, 32'h8000);
        apb(1, ADDR_BUF, 32'h1234);
        chk({sck_oe_n, sdo_oe_n}, 0, "master drives pins");
        apb(1, ADDR_BUF, 32'hbeef);
        rd(ADDR_STAT, 32'h8002, "second word pending");
        poll(STAT_RBF);
        rd(ADDR_STAT, 32'h8001, "second word loaded");
        poll(STAT_ROV);
        rd(ADDR_STAT, 32'h8041, "overflow flagged");
        chk(p_rx, 16'hbeef, "peer got second word");
        rd(ADDR_BUF, 32'ha5c3, "first word kept");
        rd(ADDR_STAT, 32'h8040, "overflow stays set");
        rd(ADDR_ISTS, 32'h7, "events latched");
        irq_is(1);
        apb(1, ADDR_IMASK, 32'h0);
        irq_is(0);
        apb(1, ADDR_IMASK, 32'h7);
        irq_is(1);
        apb(1, ADDR_ISTS, 32'h7);
        irq_is(0);
        rd(ADDR_ISTS, 32'h0, "events cleared");
        apb(1, ADDR_STAT, 32'h8040);
        rd(ADDR_STAT, 32'h8000, "overflow cleared");
        $display("test master done");
        // Slave: peer makes the clock inside one frame
        apb(1, ADDR_CFG, 32'h0);
        apb(1, ADDR_BUF, 32'h0ff0);
        chk({sck_oe_n, sdo_oe_n}, 32'h3, "slave pins released");
        ssp_peer_inst.load(16'h3c96);
        ssp_peer_inst.frame();
        repeat (8) @(posedge clk);
        chk(p_rx, 16'h0ff0, "slave sent");
        rd(ADDR_BUF, 32'h3c96, "slave received");
        $display("test slave done");
        // Idle stop: no word is taken while idle is requested
        idle <= 1'b1;
        apb(1, ADDR_STAT, 32'ha000);
        apb(1, ADDR_BUF, 32'h5a5a);
        rd(ADDR_STAT, 32'ha002, "idle holds word");
        idle <= 1'b0;
        rd(ADDR_STAT, 32'ha000, "word loaded after idle");
        $display("test idle done");
        complete_run();
    end
endmodule // test_spi_serial_port
